// ===== verilog/iq_average_power_detector.v
/*
  I/Q average power detector: register file, per-pair power from the top
  sample bits, windowed averaging, limit compare, trip flag and held maximum.
  Assumes samples arrive synchronous to clk with a valid strobe, and that
  the interrupt logic outside sends a one-cycle clear pulse.
*/
//
// Contract
// [RQ1] 13-bit limit split over two registers
// [RQ2] Average above limit raises trip flag
// [RQ3] Average computed only when enable set
// [RQ4] Window is 2^(9+exponent) sample pairs; exponent above 10 is clamped to 10
// [RQ5] Readback shows live average when untripped
// [RQ6] After trip readback holds max until clear
// [RQ7] Only six sample MSBs used for power
// [RQ8] Disabled clears average and trip flag
`timescale 1ns/1ns
`include "iq_power_map.vh"
module iq_average_power_detector #(
  parameter SAMPLE_W = 16,
  parameter PWR_W = 13
) (
  input wire clk,
  input wire resetn,
  input wire sampleValid,
  input wire [SAMPLE_W-1:0] sampleI,
  input wire [SAMPLE_W-1:0] sampleQ,
  input wire [11:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  input wire powerIrqClear,
  output reg [7:0] regRdData,
  output reg regRdValid,
  output reg powerTripFlag
);
  localparam MS = `SAMPLE_MSBS;

  // Reset release synchroniser
  reg rstMeta_reg;
  reg rstSync_reg;
  wire rstn;

  // Register file
  reg [7:0] limitLow_reg;
  reg [`LIMIT_HIGH_MSB:0] limitHigh_reg;
  reg calcOn_reg;
  reg [`EXPONENT_MSB:0] exponent_reg;
  wire [PWR_W-1:0] powerLimit;

  // Power pipeline
  reg signed [MS-1:0] iTop;
  reg signed [MS-1:0] qTop;
  reg signed [2*MS-1:0] iSq;
  reg signed [2*MS-1:0] qSq;
  reg [PWR_W-1:0] pairPower_reg;
  reg pairValid_reg;
  wire avgValid;
  wire [PWR_W-1:0] avgValue;

  // Trip state and readback
  reg [PWR_W-1:0] readback_reg;
  reg [PWR_W-1:0] readback_next;
  reg trip_next;
  wire crossing;

  // Async assert, synchronous release; only the second stage is used
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end
  assign rstn = rstSync_reg;

  // Register writes; reserved bits are dropped on the way in
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      limitLow_reg <= `LIMIT_LOW_RESET;
      limitHigh_reg <= `LIMIT_HIGH_RESET;
      calcOn_reg <= `CALC_ON_RESET;
      exponent_reg <= `EXPONENT_RESET;
    end else if (regWrite) begin
      case (regAddr)
        // [RQ1] Limit low byte
        `LIMIT_LOW_ADDR: begin
          limitLow_reg <= regWrData;
        end
        // [RQ1] Limit upper bits
        `LIMIT_HIGH_ADDR: begin
          limitHigh_reg <= regWrData[`LIMIT_HIGH_MSB:0];
        end
        `AVG_CONFIG_ADDR: begin
          calcOn_reg <= regWrData[`CALC_ON_BIT];
          exponent_reg <= regWrData[`EXPONENT_MSB:0];
        end
        default: begin
          limitLow_reg <= limitLow_reg;
        end
      endcase
    end
  end

  // [RQ1] Limit assembled from both
  assign powerLimit = {limitHigh_reg, limitLow_reg};

  // Register reads, one cycle latency; unmapped and reserved read zero
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regRdData <= 8'h00;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRead;
      if (regRead) begin
        case (regAddr)
          `LIMIT_LOW_ADDR: begin
            regRdData <= limitLow_reg;
          end
          `LIMIT_HIGH_ADDR: begin
            regRdData <= {3'h0, limitHigh_reg};
          end
          `AVG_CONFIG_ADDR: begin
            regRdData <= {calcOn_reg, 3'h0, exponent_reg};
          end
          // [RQ5] Readback low byte
          `READBACK_LOW_ADDR: begin
            regRdData <= readback_reg[7:0];
          end
          `READBACK_HIGH_ADDR: begin
            regRdData <= {3'h0, readback_reg[PWR_W-1:8]};
          end
          default: begin
            regRdData <= 8'h00;
          end
        endcase
      end
    end
  end

  // [RQ7] Six sample MSBs
  always @* begin
    iTop = sampleI[SAMPLE_W-1:SAMPLE_W-MS];
    qTop = sampleQ[SAMPLE_W-1:SAMPLE_W-MS];
    iSq = iTop * iTop;
    qSq = qTop * qTop;
  end

  // Register the pair power so the squarers sit in their own stage.
  // Max square is 1024 each, so the sum of 2048 always fits 13 bits.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pairPower_reg <= {PWR_W{1'b0}};
      pairValid_reg <= 1'b0;
    end else begin
      // [RQ3] Gate on enable
      pairValid_reg <= sampleValid & calcOn_reg;
      pairPower_reg <= {1'b0, iSq} + {1'b0, qSq};
    end
  end

  // [RQ4] Windowed averager
  power_avg_window #(
    .PWR_W(PWR_W),
    .BASE_LOG2(`WINDOW_BASE_LOG2),
    .MAX_EXP(`EXPONENT_MAX)
  ) avgWindow (
    .clk(clk),
    .rstn(rstn),
    .calcOn(calcOn_reg),
    .exponent(exponent_reg),
    .pairValid(pairValid_reg),
    .pairPower(pairPower_reg),
    .avgValid(avgValid),
    .avgValue(avgValue)
  );

  // [RQ2] Crossing means strictly above
  assign crossing = avgValid & (avgValue > powerLimit);

  // Trip and readback next state. A crossing in the same cycle as the
  // clear pulse keeps the flag set, so no event is lost.
  always @* begin
    trip_next = powerTripFlag;
    readback_next = readback_reg;
    if (!calcOn_reg) begin
      // [RQ8] Suppress trip flag
      trip_next = 1'b0;
      readback_next = `READBACK_RESET;
    end else if (crossing) begin
      // [RQ2] Set trip flag
      trip_next = 1'b1;
      // [RQ6] Keep the maximum
      if (!powerTripFlag || (avgValue > readback_reg)) begin
        readback_next = avgValue;
      end
    end else begin
      if (powerIrqClear) begin
        // [RQ6] Clear releases hold
        trip_next = 1'b0;
      end
      // [RQ5] Follow live average
      if (avgValid && (!powerTripFlag || powerIrqClear)) begin
        readback_next = avgValue;
      end
    end
  end

  // Trip state flops
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      powerTripFlag <= 1'b0;
      readback_reg <= `READBACK_RESET;
    end else begin
      powerTripFlag <= trip_next;
      readback_reg <= readback_next;
    end
  end
endmodule

// ===== common/iq_power_map.vh
/*
  Register map, field positions, reset values and sizing constants of the
  I/Q average power detector.
  Assumes it is included by bare name from files that need the map.
*/
`ifndef IQ_POWER_MAP_VH
`define IQ_POWER_MAP_VH

// Register offsets on the byte-wide register port
`define LIMIT_LOW_ADDR 12'h060
`define LIMIT_HIGH_ADDR 12'h061
`define AVG_CONFIG_ADDR 12'h062
`define READBACK_LOW_ADDR 12'h063
`define READBACK_HIGH_ADDR 12'h064

// Field positions
`define LIMIT_HIGH_MSB 4
`define CALC_ON_BIT 7
`define EXPONENT_MSB 3
`define READBACK_HIGH_MSB 4

// Reset values
`define LIMIT_LOW_RESET 8'h00
`define LIMIT_HIGH_RESET 5'h00
`define CALC_ON_RESET 1'b0
`define EXPONENT_RESET 4'h0
`define READBACK_RESET 13'h0000

// Window sizing: 2^(BASE + exponent) pairs, exponent limited to MAX
`define WINDOW_BASE_LOG2 9
`define EXPONENT_MAX 4'ha

// Sample bits kept for the power computation
`define SAMPLE_MSBS 6

`endif

// ===== verilog/power_avg_window.v
/*
  Windowed power averager: sums per-pair power values over 2^(BASE+exp)
  pairs and emits the average once per window.
  Assumes an active-low reset that asserts at once and releases on a clock
  edge, and a power value valid with pairValid in the same cycle.
*/
`timescale 1ns/1ns
module power_avg_window #(
  parameter PWR_W = 13,
  parameter BASE_LOG2 = 9,
  parameter MAX_EXP = 10
) (
  input wire clk,
  input wire rstn,
  input wire calcOn,
  input wire [3:0] exponent,
  input wire pairValid,
  input wire [PWR_W-1:0] pairPower,
  output reg avgValid,
  output reg [PWR_W-1:0] avgValue
);
  localparam CNT_W = BASE_LOG2 + MAX_EXP;
  localparam ACC_W = PWR_W + CNT_W;

  reg [CNT_W-1:0] pairCount_reg;
  reg [ACC_W-1:0] powerSum_reg;
  reg [3:0] expUsed;
  reg [4:0] shiftAmt;
  reg [CNT_W-1:0] lastCount;
  reg [ACC_W-1:0] sumNext;
  reg [ACC_W-1:0] shifted;

  // Clamp exponent so a bad setting cannot overflow the sum or counter
  always @* begin
    expUsed = (exponent > MAX_EXP[3:0]) ? MAX_EXP[3:0] : exponent;
    shiftAmt = BASE_LOG2[4:0] + {1'b0, expUsed};
    lastCount = ({CNT_W{1'b1}} >> (CNT_W[4:0] - shiftAmt));
    sumNext = powerSum_reg + {{CNT_W{1'b0}}, pairPower};
    shifted = sumNext >> shiftAmt;
  end

  // Block average: cheaper than a true sliding sum, which would need
  // up to 2^19 stored pairs
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pairCount_reg <= {CNT_W{1'b0}};
      powerSum_reg <= {ACC_W{1'b0}};
      avgValid <= 1'b0;
      avgValue <= {PWR_W{1'b0}};
    end else if (!calcOn) begin
      // [RQ8] Disable clears average
      pairCount_reg <= {CNT_W{1'b0}};
      powerSum_reg <= {ACC_W{1'b0}};
      avgValid <= 1'b0;
      avgValue <= {PWR_W{1'b0}};
    end else begin
      avgValid <= 1'b0;
      if (pairValid) begin
        // [RQ4] Window end check
        if (pairCount_reg >= lastCount) begin
          pairCount_reg <= {CNT_W{1'b0}};
          powerSum_reg <= {ACC_W{1'b0}};
          avgValid <= 1'b1;
          avgValue <= shifted[PWR_W-1:0];
        end else begin
          pairCount_reg <= pairCount_reg + {{(CNT_W-1){1'b0}}, 1'b1};
          powerSum_reg <= sumNext;
        end
      end
    end
  end
endmodule

// ===== sim/iq_power_checker_assertions.sv
/* Port checker for the I/Q power detector.
   Assumes it is bound onto the detector top. */
`timescale 1ns/1ns
`include "iq_power_map.vh"
module iq_power_checker #(
  parameter SAMPLE_W = 16,
  parameter PWR_W = 13
) (
  input wire clk,
  input wire resetn,
  input wire sampleValid,
  input wire [SAMPLE_W-1:0] sampleI,
  input wire [SAMPLE_W-1:0] sampleQ,
  input wire [11:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  input wire powerIrqClear,
  input wire [7:0] regRdData,
  input wire regRdValid,
  input wire powerTripFlag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Write that turns the power calculation off
  wire offWr = regWrite && regAddr == `AVG_CONFIG_ADDR && !regWrData[`CALC_ON_BIT];
  sequence limWr;
    regWrite && !regRead && regAddr == `LIMIT_LOW_ADDR;
  endsequence
  sequence limRd;
    regRead && !regWrite && regAddr == `LIMIT_LOW_ADDR;
  endsequence
  limit_round_trip_a: assert property (
    limWr ##1 !regWrite ##1 limRd |=> regRdData == $past(regWrData, 3)) else $error("limit lost");
  limit_reserved_a: assert property (
    regRead && regAddr == `LIMIT_HIGH_ADDR |=> regRdData[7:5] == 3'h0) else $error("limit rsv");
  config_reserved_a: assert property (
    regRead && regAddr == `AVG_CONFIG_ADDR |=> regRdData[6:4] == 3'h0) else $error("cfg rsv");
  read_answer_a: assert property (
    1'b1 |=> regRdValid == $past(regRead)) else $error("read answer");
  trip_cause_a: assert property (
    $rose(powerTripFlag) |-> $past(sampleValid, 3)) else $error("trip without window");
  trip_hold_a: assert property (
    powerTripFlag && !powerIrqClear && !offWr && !$past(offWr) |=> powerTripFlag)
    else $error("trip dropped");
  clear_drops_a: assert property (
    powerIrqClear && !$past(sampleValid) && !$past(sampleValid, 2) |=> !powerTripFlag)
    else $error("clear ignored");
  off_clears_a: assert property (
    offWr |=> ##1 !powerTripFlag) else $error("trip while off");
endmodule

bind iq_average_power_detector iq_power_checker #(.SAMPLE_W(SAMPLE_W), .PWR_W(PWR_W)) chk (
  .clk(clk), .resetn(resetn), .sampleValid(sampleValid), .sampleI(sampleI),
  .sampleQ(sampleQ), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
  .regRead(regRead), .powerIrqClear(powerIrqClear), .regRdData(regRdData),
  .regRdValid(regRdValid), .powerTripFlag(powerTripFlag));

// ===== sim/pair_source.sv
/* Upstream datapath model sending I/Q pairs.
   Assumes send is called from the bench's main thread. */
`timescale 1ns/1ns
module pair_source (
  input wire clk,
  output reg sampleValid,
  output reg [15:0] sampleI,
  output reg [15:0] sampleQ
);
  reg [9:0] junk;
  // Low bits churn on purpose: only the top six may count
  task send(input integer n, input [5:0] i6, input [5:0] q6);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1) begin
        @(posedge clk);
        junk = junk + 10'h25b;
        sampleValid <= 1'b1;
        sampleI <= {i6, junk};
        sampleQ <= {q6, ~junk};
      end
      @(posedge clk);
      sampleValid <= 1'b0;
      // Idle lanes show garbage, not the last pair
      sampleI <= ~sampleI;
      sampleQ <= ~sampleQ;
    end
  endtask
  initial begin
    sampleValid = 1'b0;
    sampleI = 16'h0000;
    sampleQ = 16'h0000;
    junk = 10'h000;
  end
endmodule

// ===== sim/iq_average_power_detector_test.sv
/* Self-checking bench for the I/Q power detector.
   Assumes the pair source and the checker bind are compiled first. */
`timescale 1ns/1ns
`include "iq_power_map.vh"
module iq_average_power_detector_test;
  reg clk, resetn, regWrite, regRead, powerIrqClear;
  reg [11:0] regAddr;
  reg [7:0] regWrData, got;
  wire sampleValid, regRdValid, powerTripFlag;
  wire [15:0] sampleI, sampleQ;
  wire [7:0] regRdData;
  integer failures, samplesChecked, k;
  pair_source src (.clk(clk), .sampleValid(sampleValid), .sampleI(sampleI), .sampleQ(sampleQ));
  iq_average_power_detector DUT (.clk(clk), .resetn(resetn), .sampleValid(sampleValid),
    .sampleI(sampleI), .sampleQ(sampleQ), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .powerIrqClear(powerIrqClear),
    .regRdData(regRdData), .regRdValid(regRdValid), .powerTripFlag(powerTripFlag));
  task check(input [12:0] g, input [12:0] e);
    begin
      samplesChecked = samplesChecked + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask
  task wr(input [11:0] a, input [7:0] d);
    begin
      @(posedge clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regWrite <= 1'b0;
    end
  endtask
  // Answer is checked just after the same edge that takes the read
  task rd(input [11:0] a, input [7:0] e);
    begin
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      #1;
      check({12'h000, regRdValid}, 13'h0001);
      got = regRdData;
      check({5'h00, got}, {5'h00, e});
    end
  endtask
  // Readback pair read back to back, between window ends
  task power(input [12:0] e);
    begin
      rd(`READBACK_LOW_ADDR, e[7:0]);
      rd(`READBACK_HIGH_ADDR, {3'h0, e[12:8]});
    end
  endtask
  task flag(input e);
    check({12'h000, powerTripFlag}, {12'h000, e});
  endtask
  // 512 pairs, one whole window at exponent 0, then the pipeline settles
  task win(input [5:0] i6, input [5:0] q6);
    begin
      src.send(512, i6, q6);
      repeat (4) @(posedge clk);
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d failures %0d", samplesChecked, failures);
      if (failures == 0 && samplesChecked > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Watchdog so a hang still reaches the verdict
  initial begin
    repeat (60000) @(posedge clk);
    failures = failures + 1;
    print_verdict;
  end
  initial begin
    {resetn, regWrite, regRead, powerIrqClear} = 4'h0;
    regAddr = 12'h000;
    regWrData = 8'h00;
    failures = 0;
    samplesChecked = 0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    for (k = 0; k < 6; k = k + 1)
      rd(12'h060 + k[11:0], 8'h00);
    wr(`LIMIT_LOW_ADDR, 8'hff);
    rd(`LIMIT_LOW_ADDR, 8'hff);
    wr(`LIMIT_HIGH_ADDR, 8'hff);
    rd(`LIMIT_HIGH_ADDR, 8'h1f);
    wr(`AVG_CONFIG_ADDR, 8'h7a);
    rd(`AVG_CONFIG_ADDR, 8'h0a);
    wr(`READBACK_LOW_ADDR, 8'h55);
    win(6'h1f, 6'h20);
    power(13'h0000);
    wr(`AVG_CONFIG_ADDR, 8'h80);
    win(6'h1f, 6'h20);
    power(13'h07c1);
    flag(1'b0);
    wr(`AVG_CONFIG_ADDR, 8'h81);
    win(6'h00, 6'h3f);
    power(13'h07c1);
    win(6'h3d, 6'h00);
    power(13'h0005);
    wr(`LIMIT_HIGH_ADDR, 8'h01);
    wr(`LIMIT_LOW_ADDR, 8'h00);
    wr(`AVG_CONFIG_ADDR, 8'h80);
    win(6'h10, 6'h10);
    flag(1'b1);
    power(13'h0200);
    win(6'h1f, 6'h20);
    power(13'h07c1);
    win(6'h10, 6'h10);
    power(13'h07c1);
    win(6'h00, 6'h3f);
    power(13'h07c1);
    @(posedge clk);
    powerIrqClear <= 1'b1;
    @(posedge clk);
    powerIrqClear <= 1'b0;
    #1;
    flag(1'b0);
    power(13'h07c1);
    win(6'h00, 6'h3f);
    power(13'h0001);
    win(6'h1f, 6'h20);
    flag(1'b1);
    wr(`AVG_CONFIG_ADDR, 8'h00);
    @(posedge clk);
    #1;
    flag(1'b0);
    power(13'h0000);
    // Half a window of loud pairs, then off and on: the stale sum must go
    wr(`AVG_CONFIG_ADDR, 8'h80);
    src.send(256, 6'h1f, 6'h20);
    wr(`AVG_CONFIG_ADDR, 8'h00);
    wr(`AVG_CONFIG_ADDR, 8'h80);
    win(6'h00, 6'h3f);
    power(13'h0001);
    flag(1'b0);
    print_verdict;
  end
endmodule
